// file: hw/i2c_byte_engine.v
`timescale 1ns/1ps
`include "sensor_hub_regs.vh"
module i2c_byte_engine (
    input  wire       clock,
    input  wire       nrst,
    input  wire       cmdValid,
    input  wire [1:0] cmd,
    input  wire [7:0] txByte,
    input  wire       sendAck,
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        done,
    output reg        nack,
    output reg  [7:0] rxByte,
    output reg        sclOe,
    output reg        sdaOe
);
    // Quarter bit period in clock cycles, at least one
    localparam QTR_RAW = (`HUB_SCL_PERIOD_NS / 4) / `HUB_CLK_PERIOD_NS;
    localparam [3:0] QUARTER = (QTR_RAW < 1) ? 4'd1 : QTR_RAW[3:0];
    localparam [1:0] E_IDLE = 2'd0, E_START = 2'd1, E_STOP = 2'd2, E_BIT = 2'd3;

    reg [1:0] state;
    reg [1:0] phase;
    reg [3:0] tickCnt;
    reg [3:0] bitIdx;
    reg       isRead;
    reg       ackOut;

    // Start, stop and nine-bit byte sequencing, SCL stretch aware
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state   <= E_IDLE;
            phase   <= 2'd0;
            tickCnt <= 4'h0;
            bitIdx  <= 4'h0;
            isRead  <= 1'b0;
            ackOut  <= 1'b0;
            done    <= 1'b0;
            nack    <= 1'b0;
            rxByte  <= 8'h00;
            sclOe   <= 1'b0;
            sdaOe   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state == E_IDLE) begin
                if (cmdValid) begin
                    case (cmd)
                        `HUB_CMD_START: state <= E_START;
                        `HUB_CMD_STOP:  state <= E_STOP;
                        default:        state <= E_BIT;
                    endcase
                    isRead  <= (cmd == `HUB_CMD_READ);
                    rxByte  <= txByte;
                    ackOut  <= sendAck;
                    bitIdx  <= 4'h0;
                    phase   <= 2'd0;
                    tickCnt <= QUARTER - 4'd1;
                end
            end else if (tickCnt != 4'h0) begin
                tickCnt <= tickCnt - 4'd1;
            end else if (!(phase == 2'd2 && !sclIn)) begin
                tickCnt <= QUARTER - 4'd1;
                phase   <= phase + 2'd1;
                case (state)
                    E_START: begin
                        case (phase)
                            2'd0:    sdaOe <= 1'b0;
                            2'd1:    sclOe <= 1'b0;
                            2'd2:    sdaOe <= 1'b1;
                            default: sclOe <= 1'b1;
                        endcase
                    end
                    E_STOP: begin
                        case (phase)
                            2'd0:    sdaOe <= 1'b1;
                            2'd1:    sclOe <= 1'b0;
                            2'd2:    sdaOe <= 1'b0;
                            default: sdaOe <= 1'b0;
                        endcase
                    end
                    default: begin
                        case (phase)
                            2'd0: sdaOe <= (bitIdx == 4'd8) ? (isRead & ackOut)
                                                             : (!isRead & !rxByte[7]);
                            2'd1: sclOe <= 1'b0;
                            2'd2: begin
                                if (bitIdx == 4'd8)
                                    nack <= sdaIn;
                                else
                                    rxByte <= {rxByte[6:0], sdaIn};
                            end
                            default: sclOe <= 1'b1;
                        endcase
                    end
                endcase
                if (phase == 2'd3) begin
                    if (state != E_BIT || bitIdx == 4'd8) begin
                        state <= E_IDLE;
                        done  <= 1'b1;
                    end else begin
                        bitIdx <= bitIdx + 4'd1;
                    end
                end
            end
        end
    end
endmodule // i2c_byte_engine

// file: hw/pin_sync.v
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 2
) (
    input  wire             clock,
    input  wire             nrst,
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] pinSync
);
    reg [WIDTH-1:0] firstStage;

    // Two flops; lines idle high
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            firstStage <= {WIDTH{1'b1}};
            pinSync    <= {WIDTH{1'b1}};
        end else begin
            firstStage <= pinIn;
            pinSync    <= firstStage;
        end
    end
endmodule // pin_sync

// file: hw/sensor_hub.v
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "sensor_hub_regs.vh"
module sensor_hub (
    input  wire        clock,
    input  wire        nrst,
    input  wire [7:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    input  wire        hubTrigger,
    input  wire        sclIn,
    output reg         sclOut,
    output wire        sclOe,
    input  wire        sdaIn,
    output reg         sdaOut,
    output wire        sdaOe,
    output reg  [7:0]  hubDataByte,
    output reg         hubDataValid,
    output reg  [1:0]  hubDataSlot,
    output reg         hubDataBatch
);
    localparam [3:0] S_IDLE   = 4'd0;
    localparam [3:0] S_SLOT   = 4'd1;
    localparam [3:0] S_START  = 4'd2;
    localparam [3:0] S_ADDRW  = 4'd3;
    localparam [3:0] S_PTR    = 4'd4;
    localparam [3:0] S_DATA   = 4'd5;
    localparam [3:0] S_RSTART = 4'd6;
    localparam [3:0] S_ADDRR  = 4'd7;
    localparam [3:0] S_READ   = 4'd8;
    localparam [3:0] S_STOP   = 4'd9;
    localparam [3:0] S_ADV    = 4'd10;

    // Register bus decode
    wire [5:0]  regIdx   = address[7:2];
    wire        aligned  = (address[1:0] == 2'b00);
    wire        wrStrobe = write & ~waitrequest & aligned;
    wire        rdDone   = read & ~waitrequest & aligned;

    // Control and data registers
    reg  [7:0]  masterCtrl;
    reg  [7:0]  slot1WriteByte;
    wire [31:0] slotAddrV;
    wire [31:0] slotPtrV;
    wire [31:0] slotCfgV;

    // Status flags
    reg  [3:0]  nackFlag;
    reg         hubCycleDone;
    reg         singleWriteComplete;
    wire [7:0]  statusByte;

    // Sequencer
    reg  [3:0]  state;
    reg  [1:0]  slot;
    reg  [2:0]  readLeft;
    reg         doWrite;
    reg         opFail;
    reg         waiting;
    reg         writtenOnce;
    reg         engValid;
    reg  [3:0]  nackSet;
    reg         singleSet;
    reg  [1:0]  engCmd;
    reg  [7:0]  engByte;
    reg  [7:0]  rdMux;
    wire        engDone;
    wire        engNack;
    wire [7:0]  engRx;
    wire        sclSync;
    wire        sdaSync;
    integer     k;

    // Per-slot address, pointer and configuration registers
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : slotReg
            localparam integer IDX_W = `HUB_SLOT1_TARGET_ADDRESS_IDX + 3 * g;
            localparam [5:0] ADDR_IDX = IDX_W[5:0];
            reg [7:0] addrR;
            reg [7:0] ptrR;
            reg [7:0] cfgR;
            always @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    addrR <= `HUB_REG_RESET;
                    ptrR  <= `HUB_REG_RESET;
                    cfgR  <= `HUB_REG_RESET;
                end else if (wrStrobe) begin
                    if (regIdx == ADDR_IDX)
                        addrR <= writedata[7:0];
                    if (regIdx == ADDR_IDX + 6'd1)
                        ptrR <= writedata[7:0];
                    if (regIdx == ADDR_IDX + 6'd2)
                        cfgR <= writedata[7:0];
                end
            end
            assign slotAddrV[8*g +: 8] = addrR;
            assign slotPtrV[8*g +: 8]  = ptrR;
            assign slotCfgV[8*g +: 8]  = cfgR;
        end
    endgenerate

    // Fields of the slot now being serviced
    wire [7:0]  curAddr   = slotAddrV[8*slot +: 8];
    wire [7:0]  curPtr    = slotPtrV[8*slot +: 8];
    wire [7:0]  curCfg    = slotCfgV[8*slot +: 8];
    wire        curReadEn = curAddr[`HUB_ADDR_RDEN_BIT];
    wire [2:0]  curCount  = curCfg[2:0];
    wire [1:0]  activeSensorCount = masterCtrl[`HUB_CTRL_COUNT_LSB +: 2];
    wire        singleWriteMode   = masterCtrl[`HUB_CTRL_SINGLE_WR_BIT];
    wire        hubEnable         = masterCtrl[`HUB_CTRL_ENABLE_BIT];
    wire        slot1Write        = (slot == 2'd0) && !curReadEn;

    // Status layout, bits 2 and 1 held at zero
    assign statusByte = {singleWriteComplete, nackFlag, 2'b00, hubCycleDone};

    // Master control and slot one write byte
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            masterCtrl     <= `HUB_REG_RESET;
            slot1WriteByte <= `HUB_REG_RESET;
        end else if (wrStrobe) begin
            if (regIdx == `HUB_MASTER_CONTROL_IDX)
                masterCtrl <= writedata[7:0];
            if (regIdx == `HUB_SLOT1_WRITE_DATA_IDX)
                slot1WriteByte <= writedata[7:0];
        end
    end

    // Read mux; unmapped and status-write reads as zero effect
    always @* begin
        rdMux = 8'h00;
        for (k = 0; k < 4; k = k + 1) begin
            if (regIdx == `HUB_SLOT1_TARGET_ADDRESS_IDX + 3 * k)
                rdMux = slotAddrV[8*k +: 8];
            if (regIdx == `HUB_SLOT1_REG_POINTER_IDX + 3 * k)
                rdMux = slotPtrV[8*k +: 8];
            if (regIdx == `HUB_SLOT1_CONFIG_IDX + 3 * k)
                rdMux = slotCfgV[8*k +: 8];
        end
        if (regIdx == `HUB_MASTER_CONTROL_IDX)
            rdMux = masterCtrl;
        if (regIdx == `HUB_SLOT1_WRITE_DATA_IDX)
            rdMux = slot1WriteByte;
        if (regIdx == `HUB_STATUS_IDX)
            rdMux = statusByte;
        if (!aligned)
            rdMux = 8'h00;
    end

    // Avalon slave: one wait cycle, then data and release
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end else begin
            if (!waitrequest)
                waitrequest <= 1'b1;
            else if (read || write)
                waitrequest <= 1'b0;
            if (read && waitrequest)
                readdata <= {24'h000000, rdMux};
        end
    end

    // Sticky flags, cleared by a status read; a set wins
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nackFlag            <= 4'h0;
            singleWriteComplete <= 1'b0;
        end else begin
            if (rdDone && regIdx == `HUB_STATUS_IDX) begin
                nackFlag            <= nackSet;
                singleWriteComplete <= singleSet;
            end else begin
                nackFlag            <= nackFlag | nackSet;
                singleWriteComplete <= singleWriteComplete | singleSet;
            end
        end
    end

    // Command and byte for the engine in each state
    always @* begin
        engCmd  = `HUB_CMD_WRITE;
        engByte = 8'h00;
        case (state)
            S_START:  engCmd = `HUB_CMD_START;
            S_RSTART: engCmd = `HUB_CMD_START;
            S_ADDRW:  engByte = {curAddr[7:1], 1'b0};
            S_PTR:    engByte = curPtr;
            S_DATA:   engByte = slot1WriteByte;
            S_ADDRR:  engByte = {curAddr[7:1], 1'b1};
            S_READ:   engCmd = `HUB_CMD_READ;
            S_STOP:   engCmd = `HUB_CMD_STOP;
            default:  engCmd = `HUB_CMD_WRITE;
        endcase
    end

    // Hub cycle sequencer
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state        <= S_IDLE;
            slot         <= 2'd0;
            readLeft     <= 3'd0;
            doWrite      <= 1'b0;
            opFail       <= 1'b0;
            waiting      <= 1'b0;
            writtenOnce  <= 1'b0;
            engValid     <= 1'b0;
            nackSet      <= 4'h0;
            singleSet    <= 1'b0;
            hubCycleDone <= 1'b0;
            hubDataByte  <= 8'h00;
            hubDataValid <= 1'b0;
            hubDataSlot  <= 2'd0;
            hubDataBatch <= 1'b0;
            sclOut       <= 1'b0;
            sdaOut       <= 1'b0;
        end else begin
            engValid     <= 1'b0;
            hubDataValid <= 1'b0;
            nackSet      <= 4'h0;
            singleSet    <= 1'b0;
            if (!singleWriteMode)
                writtenOnce <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (hubTrigger && hubEnable) begin
                        hubCycleDone <= 1'b0;
                        slot         <= 2'd0;
                        state        <= S_SLOT;
                    end
                end
                S_SLOT: begin
                    opFail   <= 1'b0;
                    readLeft <= curCount;
                    if (slot1Write) begin
                        doWrite <= 1'b1;
                        if (!singleWriteMode || !writtenOnce)
                            state <= S_START;
                        else
                            state <= S_ADV;
                    end else if (curReadEn && curCount != 3'd0) begin
                        doWrite <= 1'b0;
                        state   <= S_START;
                    end else begin
                        state <= S_ADV;
                    end
                end
                S_ADV: begin
                    if (slot == activeSensorCount) begin
                        hubCycleDone <= 1'b1;
                        state        <= S_IDLE;
                    end else begin
                        slot  <= slot + 2'd1;
                        state <= S_SLOT;
                    end
                end
                default: begin
                    if (!waiting) begin
                        engValid <= 1'b1;
                        waiting  <= 1'b1;
                    end else if (engDone) begin
                        waiting <= 1'b0;
                        if (engNack && (state == S_ADDRW || state == S_PTR ||
                                        state == S_DATA || state == S_ADDRR)) begin
                            nackSet[slot] <= 1'b1;
                            opFail        <= 1'b1;
                            state         <= S_STOP;
                        end else begin
                            case (state)
                                S_START:  state <= S_ADDRW;
                                S_ADDRW:  state <= S_PTR;
                                S_PTR:    state <= doWrite ? S_DATA : S_RSTART;
                                S_DATA:   state <= S_STOP;
                                S_RSTART: state <= S_ADDRR;
                                S_ADDRR:  state <= S_READ;
                                S_READ: begin
                                    hubDataByte  <= engRx;
                                    hubDataValid <= 1'b1;
                                    hubDataSlot  <= slot;
                                    hubDataBatch <= curCfg[`HUB_CFG_BATCH_BIT];
                                    readLeft     <= readLeft - 3'd1;
                                    if (readLeft == 3'd1)
                                        state <= S_STOP;
                                end
                                S_STOP: begin
                                    if (doWrite && !opFail && singleWriteMode) begin
                                        writtenOnce <= 1'b1;
                                        singleSet   <= 1'b1;
                                    end
                                    state <= S_ADV;
                                end
                                default: state <= S_IDLE;
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    // Two-flop sampling of the bus lines
    pin_sync #(
        .WIDTH (2)
    ) busSync (
        .clock   (clock),
        .nrst    (nrst),
        .pinIn   ({sclIn, sdaIn}),
        .pinSync ({sclSync, sdaSync})
    );

    // Bit-level bus engine
    i2c_byte_engine engine (
        .clock    (clock),
        .nrst     (nrst),
        .cmdValid (engValid),
        .cmd      (engCmd),
        .txByte   (engByte),
        .sendAck  (readLeft != 3'd1),
        .sclIn    (sclSync),
        .sdaIn    (sdaSync),
        .done     (engDone),
        .nack     (engNack),
        .rxByte   (engRx),
        .sclOe    (sclOe),
        .sdaOe    (sdaOe)
    );
endmodule // sensor_hub

// file: inc/sensor_hub_regs.vh
// What this block does
// - Slots two and three use their 8-bit register pointer as the register address on that sensor, gated by the slot read enable.
// - Slot four only ever reads its read count of bytes starting at the register its 8-bit pointer selects, gated by its read enable.
// - Slots two to four each hold a 3-bit read count that resets to zero.
// - Slots two to four each hold a FIFO batching enable that resets to 0 and marks their read data for batching.
// - Slot three and four address registers hold a 7-bit target address above a read enable bit that resets to 0.
// - An 8-bit write byte, reset to zero, is sent to the first sensor when that slot is set for a write.
// - In single write mode the completion flag is set once the first slot's write has finished without a not-acknowledge.
// - Each of the four slots has a not-acknowledge flag, reset to 0, set when its sensor does not acknowledge.
// - The hub cycle done bit reads 1 once the hub cycle has ended and 0 while it has not, and resets to 0.
// - The status register is read-only and its bits 2 and 1 read as zero.
// - A 2-bit field selects how many sensors are serviced per cycle, 00 for one up to 11 for four.
// - With single write mode set the first slot writes in each hub cycle until one write completes without a not-acknowledge, otherwise in every cycle.
// - The first slot direction bit selects a write when 0 and a read when 1.
// - The second slot address register carries a read enable that permits reads on the second sensor.
`ifndef SENSOR_HUB_REGS_VH
`define SENSOR_HUB_REGS_VH

// Register indexes, byte address is four times the index
`define HUB_MASTER_CONTROL_IDX       6'h14
`define HUB_SLOT1_TARGET_ADDRESS_IDX 6'h15
`define HUB_SLOT1_REG_POINTER_IDX    6'h16
`define HUB_SLOT1_CONFIG_IDX         6'h17
`define HUB_SLOT2_TARGET_ADDRESS_IDX 6'h18
`define HUB_SLOT2_REG_POINTER_IDX    6'h19
`define HUB_SLOT2_CONFIG_IDX         6'h1A
`define HUB_SLOT3_TARGET_ADDRESS_IDX 6'h1B
`define HUB_SLOT3_REG_POINTER_IDX    6'h1C
`define HUB_SLOT3_CONFIG_IDX         6'h1D
`define HUB_SLOT4_TARGET_ADDRESS_IDX 6'h1E
`define HUB_SLOT4_REG_POINTER_IDX    6'h1F
`define HUB_SLOT4_CONFIG_IDX         6'h20
`define HUB_SLOT1_WRITE_DATA_IDX     6'h21
`define HUB_STATUS_IDX               6'h22

// Field positions
`define HUB_CTRL_COUNT_LSB     0
`define HUB_CTRL_ENABLE_BIT    2
`define HUB_CTRL_SINGLE_WR_BIT 6
`define HUB_ADDR_RDEN_BIT      0
`define HUB_CFG_BATCH_BIT      3
`define HUB_STAT_DONE_BIT      0
`define HUB_STAT_NACK_LSB      3
`define HUB_STAT_SINGLE_BIT    7

// Reset values
`define HUB_REG_RESET          8'h00

// Timing
`define HUB_CLK_PERIOD_NS      25
`define HUB_SCL_PERIOD_NS      200

// Byte engine commands
`define HUB_CMD_START          2'h0
`define HUB_CMD_WRITE          2'h1
`define HUB_CMD_READ           2'h2
`define HUB_CMD_STOP           2'h3

`endif

// file: testbench/aux_sensor_model.sv
`timescale 1ns/1ps
module aux_sensor_model (
    input  wire       scl,
    input  wire       sda,
    input  wire [6:0] nackAddr,
    output reg        sdaPull,
    output reg  [7:0] wrByte
);
    reg [7:0] shift;
    reg [7:0] ptr;
    reg [7:0] tx;
    reg [3:0] bitNum;
    reg [3:0] byteNum;
    reg       rd;
    reg       act;
    initial begin
        sdaPull = 0;
        act = 0;
    end
    // Start or repeated start
    always @(negedge sda) if (scl) begin
        act = 1;
        bitNum = 0;
        byteNum = 0;
        rd = 0;
    end
    // Stop ends the frame
    always @(posedge sda) if (scl) act = 0;
    // Bits in on rising clock; master nack ends a read
    always @(posedge scl) if (act) begin
        if (bitNum == 8) begin
            bitNum = 0;
            byteNum = byteNum + 1;
            if (rd && sda) act = 0;
        end else begin
            shift = {shift[6:0], sda};
            bitNum = bitNum + 1;
        end
    end
    // Ack slot, then data counting up from the pointer
    always @(negedge scl) if (act) begin
        if (bitNum == 8 && byteNum == 0) rd = shift[0];
        if (bitNum == 8 && byteNum == 1 && !rd) ptr = shift;
        if (bitNum == 8 && byteNum == 2 && !rd) wrByte = shift;
        tx = ptr + {4'h0, byteNum} - 8'h1;
        if (bitNum == 8) sdaPull = rd && byteNum != 0 ? 1'b0 : byteNum != 0 || shift[7:1] != nackAddr;
        else sdaPull = rd && byteNum != 0 && !tx[7 - bitNum];
    end
endmodule // aux_sensor_model

// file: testbench/sensor_hub_props.sv
`timescale 1ns/1ps
module sensor_hub_props (
    input wire        clock,
    input wire        nrst,
    input wire [7:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        sclOut,
    input wire        sclOe,
    input wire        sdaOut,
    input wire        sdaOe,
    input wire        hubDataValid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Completed reads
    sequence rdDone; read && !waitrequest; endsequence
    sequence statRd; rdDone ##0 address == 8'h88; endsequence
    chk_bus_wait: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest) else $error("bad wait");
    chk_stat_gap: assert property (
        statRd |-> readdata[31:8] == 24'h0 && readdata[2:1] == 2'h0) else $error("bad status");
    chk_bad_addr: assert property (
        rdDone ##0 address[1:0] != 2'h0 |-> readdata == 32'h0) else $error("unmapped data");
    chk_reset_idle: assert property (
        $rose(nrst) |-> readdata == 32'h0 && waitrequest && !sclOe && !sdaOe) else $error("reset");
    chk_done_idle: assert property (
        statRd ##0 readdata[0] |-> !sclOe && !sdaOe) else $error("done while busy");
    chk_byte_pulse: assert property (
        hubDataValid |=> !hubDataValid) else $error("long pulse");
    chk_scl_high: assert property (
        $fell(sclOe) |=> !sclOe [*4]) else $error("short clock high");
    chk_pins_low: assert property (
        sclOut == 1'b0 && sdaOut == 1'b0) else $error("pin driven high");
endmodule // sensor_hub_props
bind sensor_hub sensor_hub_props chk (.clock, .nrst, .address, .read, .write, .readdata,
    .waitrequest, .sclOut, .sclOe, .sdaOut, .sdaOe, .hubDataValid);

// file: testbench/sensor_hub_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module sensor_hub_test;
    reg         clock = 0;
    reg         nrst = 0;
    reg  [7:0]  address = 0;
    reg         read = 0;
    reg         write = 0;
    reg  [31:0] writedata = 0;
    reg         hubTrigger = 0;
    reg  [6:0]  nackAddr = 7'h7F;
    wire [31:0] readdata;
    wire        waitrequest, sclOut, sclOe, sdaOut, sdaOe, sdaPull, hubDataValid, hubDataBatch;
    wire [7:0]  hubDataByte, wrByte;
    wire [1:0]  hubDataSlot;
    wire        scl = !sclOe;
    wire        sda = !(sdaOe || sdaPull);
    integer     miscompares = 0, checksDone = 0, i, v, r, s, k, n, code;
    reg  [31:0] rv;
    reg  [7:0]  ev, wb, adr[0:3], cfg[0:3], ptr[0:3];
    reg  [10:0] got[$], exp[$];
    always #12.5 clock = ~clock;
    sensor_hub dut (.clock, .nrst, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .hubTrigger, .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda), .sdaOut, .sdaOe, .hubDataByte,
        .hubDataValid, .hubDataSlot, .hubDataBatch);
    aux_sensor_model sensors (.scl, .sda, .nackAddr, .sdaPull, .wrByte);
    // Byte stream from the hub
    always @(posedge clock) if (hubDataValid) got.push_back({hubDataSlot, hubDataBatch, hubDataByte});
    // One bus access, held until waitrequest is seen low
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        integer t;
        begin
            @(posedge clock);
            address <= a;
            writedata <= {24'h0, d};
            write <= wr;
            read <= !wr;
            t = 0;
            do begin @(posedge clock); t++; end while (waitrequest !== 1'b0 && t < 50);
            if (waitrequest !== 1'b0) begin
                miscompares++;
                conclude();
            end
            rv = readdata;
            read <= 0;
            write <= 0;
        end
    endtask
    task conclude;
        begin
            $display("compares %0d mismatches %0d", checksDone, miscompares);
            if (miscompares == 0 && checksDone > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // Expected stream entry for read k of slot s
    function [10:0] expectedByte(input integer s, input integer k);
        expectedByte = {2'(s), cfg[s][3], ptr[s] + 8'(k)};
    endfunction
    initial begin
        rv = $urandom(32'h143ad68e);
        repeat (3) @(posedge clock);
        nrst <= 1;
        // Reset values, then random write and read back
        for (i = 8'h60; i <= 8'h88; i += 4) begin
            bus(0, i[7:0], 8'h00);
            `CHK(rv, 32'h0)
        end
        for (i = 8'h60; i <= 8'h84; i += 4) begin
            v = $urandom;
            if (i == 8'h68 || i == 8'h74 || i == 8'h80) v = v & 15;
            bus(1, i[7:0], v[7:0]);
            bus(0, i[7:0], 8'h00);
            `CHK(rv, {24'h0, v[7:0]})
        end
        bus(1, 8'h88, 8'hFF);
        bus(0, 8'h88, 8'h00);
        `CHK(rv, 32'h0)
        bus(0, 8'h8A, 8'h00);
        `CHK(rv, 32'h0)
        bus(1, 8'h54, 8'h20);
        // Hub cycles over every sensor count code
        for (r = 0; r < 6; r++) begin
            code = 3 - r % 4;
            nackAddr = 7'h7F;
            ev = r == 0 || r == 5 ? 8'h81 : 8'h01;
            exp = {};
            for (s = 0; s <= 3; s++) begin
                adr[s] = {2'h1, 5'($urandom), 1'($urandom % 4 != 0 || r == 0)};
                if (s == 0) adr[s] = {7'h10, 1'(r == 3)};
                cfg[s] = {4'h0, 4'($urandom) | 4'(s == 0)};
                ptr[s] = 8'($urandom);
                bus(1, 8'h60 + 8'(12 * s - 12), adr[s]);
                bus(1, 8'h64 + 8'(12 * s - 12), ptr[s]);
                bus(1, 8'h68 + 8'(12 * s - 12), cfg[s]);
            end
            if (r % 3 != 0) nackAddr = adr[r % 3 + 1][7:1];
            for (s = 0; s <= code; s++) if (adr[s][0] && cfg[s][2:0] != 0) begin
                if (adr[s][7:1] == nackAddr) ev[3 + s] = 1'b1;
                else for (k = 0; k < cfg[s][2:0]; k++) exp.push_back(expectedByte(s, k));
            end
            bus(1, 8'h84, 8'(r * 37 + 90));
            if (r == 0 || r >= 4) wb = 8'(r * 37 + 90);
            bus(1, 8'h50, (r == 4 ? 8'h04 : 8'h44) | 8'(code));
            got = {};
            hubTrigger <= 1;
            @(posedge clock);
            hubTrigger <= 0;
            if (r == 0) begin
                bus(0, 8'h88, 8'h00);
                `CHK(rv[0], 1'b0)
            end
            k = 0;
            n = 0;
            while (k < 100 && n < 20000) begin
                @(posedge clock);
                k = sclOe || sdaOe ? 0 : k + 1;
                n++;
            end
            if (n >= 20000) begin
                miscompares++;
                conclude();
            end
            bus(0, 8'h88, 8'h00);
            `CHK(rv, {24'h0, ev})
            `CHK(got.size(), exp.size())
            foreach (exp[j]) `CHK(got[j], exp[j])
            `CHK(wrByte, wb)
        end
        conclude();
    end
endmodule // sensor_hub_test
